// ---- rtl/pin_port_pkg.sv ----
// constants for the small general-purpose pin port
package pin_port_pkg;
    // register indices; the byte address on the bus is four times the index
    localparam logic [15:0] LEVEL_IDX   = 16'h1220;
    localparam logic [15:0] SET_IDX     = 16'h1222;
    localparam logic [15:0] CLEAR_IDX   = 16'h1224;
    localparam logic [15:0] DIR_IDX     = 16'h1226;
    localparam logic [15:0] PULLUP_IDX  = 16'h122a;

    // bus geometry
    localparam int          ADDR_W      = 16;
    localparam int          DATA_W      = 32;
    localparam int          SEL_W       = 4;
    localparam int          WORD_LSB    = 2;
    localparam int          WORD_W      = ADDR_W - WORD_LSB;

    // per-pin field layout
    localparam int          PIN_W       = 8;
    localparam logic [7:0]  IMPL_MASK   = 8'h0c;

    // reset values
    localparam logic [7:0]  LEVEL_RST   = 8'h00;
    localparam logic [7:0]  DIR_RST     = 8'h00;
    localparam logic [7:0]  PULLUP_RST  = 8'hff;
    localparam logic [31:0] DAT_RST     = 32'h0000_0000;
endpackage

// ---- rtl/small_pin_port_regs.sv ----
// general-purpose pin port with level, set, clear, direction and pull-up registers
`timescale 1ns/1ps

// Overview of operation
// - level register writes drive pins, only where direction selects output
// - level register reads return the live pin levels
// - only pin bits 3 and 2 exist; bits 7:4 and 1:0 are reserved
// - a one written to the set register raises that output level bit
// - a one written to the clear register lowers that output level bit
// - zeros written to set or clear do nothing; both always read zero
// - direction bit zero means input, one means output; resets to zero
// - pull-up bit one enables the pull-up, only while the pin is input
// - pull-up register resets to all ones; reserved bits stay one
module small_pin_port_regs (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [7:0]  port_pin_n_sense,
    output logic      [7:0]  port_pin_n_drive,
    output logic      [7:0]  port_pin_n_drive_en,
    output logic      [7:0]  port_pin_n_pullup
);

    // state
    logic [7:0]  level_q;
    logic [7:0]  level_d;
    logic [7:0]  dir_q;
    logic [7:0]  dir_d;
    logic [7:0]  pin_pullup_field_q;
    logic [7:0]  pin_pullup_field_d;
    logic [7:0]  pull_on_d;
    logic [7:0]  sense_meta_q;
    logic [7:0]  sense_q;
    logic        ack_q;
    logic [31:0] dat_q;
    logic [31:0] dat_d;

    // bus decode
    wire logic [13:0] word_adr  = wb_adr_i[15:2];
    wire logic        req       = wb_cyc_i & wb_stb_i;
    wire logic        go        = req & ~ack_q;
    wire logic        wr_go     = go & wb_we_i & wb_sel_i[0];
    wire logic        rd_go     = go & ~wb_we_i;
    wire logic        hit_level = word_adr == pin_port_pkg::LEVEL_IDX[13:0];
    wire logic        hit_set   = word_adr == pin_port_pkg::SET_IDX[13:0];
    wire logic        hit_clear = word_adr == pin_port_pkg::CLEAR_IDX[13:0];
    wire logic        hit_dir   = word_adr == pin_port_pkg::DIR_IDX[13:0];
    wire logic        hit_pull  = word_adr == pin_port_pkg::PULLUP_IDX[13:0];
    wire logic [7:0]  wdat      = wb_dat_i[7:0];

    // only implemented pins set as outputs may change their level bit
    wire logic [7:0]  out_mask  = dir_q & pin_port_pkg::IMPL_MASK;
    wire logic        wr_level  = wr_go & hit_level;
    wire logic        wr_set    = wr_go & hit_set;
    wire logic        wr_clear  = wr_go & hit_clear;
    wire logic        wr_dir    = wr_go & hit_dir;
    wire logic        wr_pull   = wr_go & hit_pull;

    // level next value; input-pin bits are never touched so they keep their value
    assign level_d = wr_level ? ((level_q & ~out_mask) | (wdat & out_mask))
                   : wr_set   ? (level_q | (wdat & out_mask))
                   : wr_clear ? (level_q & ~(wdat & out_mask))
                   : level_q;

    // reserved direction bits are forced low so a careless write cannot enable them
    assign dir_d = wr_dir ? (wdat & pin_port_pkg::IMPL_MASK) : dir_q;

    // reserved pull-up bits stay one regardless of what is written
    assign pin_pullup_field_d = wr_pull ? (wdat | ~pin_port_pkg::IMPL_MASK)
                                        : pin_pullup_field_q;

    // pull-up only acts on implemented input pins
    assign pull_on_d = pin_pullup_field_q & ~dir_q & pin_port_pkg::IMPL_MASK;

    // read mux; set and clear strobes and unmapped words read zero
    assign dat_d = ~rd_go    ? dat_q
                 : hit_level ? {24'h00_0000, sense_q & pin_port_pkg::IMPL_MASK}
                 : hit_dir   ? {24'h00_0000, dir_q}
                 : hit_pull  ? {24'h00_0000, pin_pullup_field_q}
                 : pin_port_pkg::DAT_RST;

    // two-flop synchroniser for the pin levels; only the second stage is read
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sense_meta_q <= 8'h00;
            sense_q      <= 8'h00;
        end else begin
            sense_meta_q <= port_pin_n_sense;
            sense_q      <= sense_meta_q;
        end
    end

    // bus slave: one-cycle ack, dropped in the cycle after it was given
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            dat_q <= pin_port_pkg::DAT_RST;
        end else begin
            ack_q <= go;
            dat_q <= dat_d;
        end
    end

    // configuration and level registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            level_q            <= pin_port_pkg::LEVEL_RST;
            dir_q              <= pin_port_pkg::DIR_RST;
            pin_pullup_field_q <= pin_port_pkg::PULLUP_RST;
        end else begin
            level_q            <= level_d;
            dir_q              <= dir_d;
            pin_pullup_field_q <= pin_pullup_field_d;
        end
    end

    // pull-up output lags the registers by a cycle so it comes from a flop
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            port_pin_n_pullup <= pin_port_pkg::IMPL_MASK;
        end else begin
            port_pin_n_pullup <= pull_on_d;
        end
    end

    // outputs straight from flops
    assign wb_ack_o            = ack_q;
    assign wb_dat_o            = dat_q;
    assign port_pin_n_drive    = level_q;
    assign port_pin_n_drive_en = dir_q;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_level_write;
        wr_level ##0 1'b1;
    endsequence

    sequence s_read_of(logic hit);
        rd_go & hit;
    endsequence

    AST_LEVEL_WRITE: assert property (
        s_level_write |=> ((port_pin_n_drive & $past(out_mask)) == ($past(wdat) & $past(out_mask))))
        else $error("level write not driven on output pins");

    AST_READ_LIVE: assert property (
        s_read_of(hit_level) |=> wb_ack_o && wb_dat_o[7:0] == ($past(sense_q) & 8'h0c))
        else $error("level read not the live pin value");

    AST_RESERVED_QUIET: assert property (
        ((port_pin_n_drive_en | port_pin_n_drive | port_pin_n_pullup)
         & ~pin_port_pkg::IMPL_MASK) == 8'h00)
        else $error("reserved pin bit active");

    AST_SET_BIT: assert property (
        wr_set |=> ((level_q & $past(wdat & out_mask)) == $past(wdat & out_mask))
                   && ((level_q & ~$past(out_mask)) == ($past(level_q) & ~$past(out_mask))))
        else $error("set strobe did not raise output level");

    AST_CLEAR_BIT: assert property (
        wr_clear |=> ((level_q & $past(wdat & out_mask)) == 8'h00)
                     && ((level_q & ~$past(wdat)) == ($past(level_q) & ~$past(wdat))))
        else $error("clear strobe did not lower output level");

    AST_STROBE_READ_ZERO: assert property (
        (s_read_of(hit_set) or s_read_of(hit_clear)) |=> wb_ack_o ##0 wb_dat_o == 32'h0)
        else $error("set or clear register read nonzero");

    AST_DIR_WRITE: assert property (
        wr_dir |=> port_pin_n_drive_en == ($past(wdat) & 8'h0c) ##1 $stable(port_pin_n_drive_en)
                   || wr_dir)
        else $error("direction write not applied");

    AST_PULL_INPUT_ONLY: assert property (
        ##1 port_pin_n_pullup == ($past(pin_pullup_field_q) & ~$past(dir_q) & 8'h0c))
        else $error("pull-up not gated by direction");

    AST_PULL_RESERVED_ONES: assert property (
        s_read_of(hit_pull) |=> (wb_dat_o[7:0] | 8'h0c) == 8'hff)
        else $error("pull-up reserved bits not one");

    AST_INPUT_HOLD: assert property (
        ##1 ((level_q & ~$past(out_mask)) == ($past(level_q) & ~$past(out_mask))))
        else $error("input pin level bit changed");

    AST_ACK_ONE_CYCLE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // handshake steps, used by the bus checks below
    sequence s_taken;
        go;
    endsequence

    sequence s_one_cycle_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    // bus handshake checks
    // a taken request is answered by exactly one ack pulse
    AST_ACK_AFTER_TAKE: assert property (
        s_taken |=> s_one_cycle_ack)
        else $error("taken request not answered by a single ack");

    // an ack never appears without a request taken the cycle before
    AST_ACK_HAS_CAUSE: assert property (
        wb_ack_o |-> $past(go))
        else $error("ack without a taken request");

    // an idle bus sees no ack, so a stray pulse cannot complete a later cycle
    AST_NO_ACK_IDLE: assert property (
        !wb_cyc_i |=> !wb_ack_o)
        else $error("ack while the bus is idle");

    // read data checks
    // reserved positions read as zero from level and direction
    AST_RESERVED_READ: assert property (
        (s_read_of(hit_level) or s_read_of(hit_dir))
        |=> (wb_dat_o[7:0] & ~pin_port_pkg::IMPL_MASK) == 8'h00)
        else $error("reserved bit read as one");

    // read data is 32 bits of which only the low byte is used
    AST_DAT_UPPER_ZERO: assert property (
        wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read data not zero");

    // read data stands until the next read is taken
    AST_DAT_HOLDS: assert property (
        !rd_go |=> $stable(wb_dat_o))
        else $error("read data changed without a read");

    // direction reads back what is stored
    AST_DIR_READBACK: assert property (
        s_read_of(hit_dir) |=> wb_dat_o[7:0] == $past(dir_q))
        else $error("direction read differs from register");

    // pull-up field reads back what is stored
    AST_PULL_READBACK: assert property (
        s_read_of(hit_pull) |=> wb_dat_o[7:0] == $past(pin_pullup_field_q))
        else $error("pull-up read differs from register");

    // holes in the map answer with zero rather than an error
    AST_UNMAPPED_READ_ZERO: assert property (
        (rd_go && !(hit_level || hit_dir || hit_pull)) |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    // register update checks
    // zero bits of a set write leave their level bits alone
    AST_SET_ZERO_KEEP: assert property (
        wr_set |=> (level_q & ~$past(wdat)) == ($past(level_q) & ~$past(wdat)))
        else $error("set write changed a bit written zero");

    // a clear write never reaches input pins
    AST_CLEAR_INPUT_IGNORED: assert property (
        wr_clear |=> (level_q & ~$past(out_mask)) == ($past(level_q) & ~$past(out_mask)))
        else $error("clear write changed an input pin level bit");

    // a level write never reaches input pins
    AST_LEVEL_INPUT_IGNORED: assert property (
        wr_level |=> (level_q & ~$past(out_mask)) == ($past(level_q) & ~$past(out_mask)))
        else $error("level write changed an input pin level bit");

    // without byte lane zero a write is acked but changes nothing
    AST_LANE_GATE: assert property (
        (go && wb_we_i && !wb_sel_i[0])
        |=> $stable(level_q) && $stable(dir_q) && $stable(pin_pullup_field_q))
        else $error("write without lane zero changed a register");

    // reads have no side effect on any register
    AST_READ_NO_CHANGE: assert property (
        rd_go |=> $stable(level_q) && $stable(dir_q) && $stable(pin_pullup_field_q))
        else $error("read changed a register");

    // level bits move only on level, set or clear writes
    AST_LEVEL_ONLY_BY_WRITE: assert property (
        !(wr_level || wr_set || wr_clear) |=> $stable(level_q))
        else $error("level bits changed without a write");

    // output enables move only on direction writes
    AST_DIR_ONLY_BY_WRITE: assert property (
        !wr_dir |=> $stable(port_pin_n_drive_en))
        else $error("output enable changed without a write");

    // turning a pin to output drives the level stored while it was input
    AST_DIR_KEEPS_LEVEL: assert property (
        wr_dir |=> port_pin_n_drive == $past(level_q))
        else $error("direction write disturbed the level bits");

    // pull-up field moves only on its own writes
    AST_PULL_ONLY_BY_WRITE: assert property (
        !wr_pull |=> $stable(pin_pullup_field_q))
        else $error("pull-up field changed without a write");

    // reserved pull-up bits come back as one whatever is written
    AST_PULL_FIELD_WRITE: assert property (
        wr_pull |=> pin_pullup_field_q == ($past(wdat) | ~pin_port_pkg::IMPL_MASK))
        else $error("pull-up write not stored with reserved bits set");

    // a pin that was driven the cycle before never has its pull-up on
    AST_PULL_OFF_OUTPUT: assert property (
        (port_pin_n_pullup & $past(port_pin_n_drive_en)) == 8'h00)
        else $error("pull-up enabled on an output pin");

endmodule

// ---- verification/pin_far_side.sv ----
// model of the outside world at the port pins
`timescale 1ns/1ps
module pin_far_side (
    input  wire logic       ref_clk,
    input  wire logic [7:0] drive,
    input  wire logic [7:0] drive_en,
    input  wire logic [7:0] pull_en,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] sense
);
    logic [7:0] float_q = 8'h55;
    // a pin nobody holds wanders, so a stale level never passes for a read
    always @(posedge ref_clk) begin
        float_q <= ~float_q;
    end
    // port drive wins, then the outside driver, then the pull-up
    assign sense = (drive_en & drive) | (~drive_en & ext_en & ext_val)
                 | (~drive_en & ~ext_en & (pull_en | float_q));
endmodule

// ---- verification/test_small_pin_port_regs.sv ----
// register and pin tests for the pin port
`timescale 1ns/1ps
module test_small_pin_port_regs;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000, dat_o;
    logic        ack;
    logic [7:0]  ext_en = 8'h00, ext_val = 8'h00, sense, drv, drv_en, pu;
    logic [3:0]  lanes = 4'hf;
    int          error_cnt = 0, samples_checked = 0, cycles = 0;
    always #50 ref_clk = ~ref_clk;
    small_pin_port_regs u_small_pin_port_regs (.ref_clk(ref_clk), .nrst(nrst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .port_pin_n_sense(sense),
        .port_pin_n_drive(drv), .port_pin_n_drive_en(drv_en), .port_pin_n_pullup(pu));
    pin_far_side u_pin_far_side (.ref_clk(ref_clk), .drive(drv), .drive_en(drv_en),
        .pull_en(pu), .ext_en(ext_en), .ext_val(ext_val), .sense(sense));
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // a hang is cut short well past the hundred or so cycles the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic cycle; data is taken at the edge that shows ack
    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d,
                       output logic [31:0] r);
        @(posedge ref_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= lanes;
        adr <= {idx[13:0], 2'b00}; dat <= {24'h000000, d};
        do @(posedge ref_clk); while (ack !== 1'b1);
        r = dat_o;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, idx, d, r);
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, idx, 8'h00, r);
        chk(r, exp);
    endtask
    // pins pass two sync flops before a read can see them
    task automatic settle();
        repeat (3) @(posedge ref_clk);
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        chk(32'(pu), 32'h0c);
        // the synchroniser restarts from zero, so give the pins time to arrive
        settle();
        rd(pin_port_pkg::LEVEL_IDX, 32'h0c);
        rd(pin_port_pkg::DIR_IDX, 32'h00);
        rd(pin_port_pkg::PULLUP_IDX, 32'hff);
        rd(16'h1228, 32'h00);
        $display("reset test done");
        wr(pin_port_pkg::LEVEL_IDX, 8'hff);
        chk(32'(drv), 32'h00);
        // a write without byte lane zero is acked but must change nothing
        lanes = 4'he;
        wr(pin_port_pkg::DIR_IDX, 8'h0c);
        lanes = 4'hf;
        chk(32'(drv_en), 32'h00);
        wr(pin_port_pkg::DIR_IDX, 8'h0c);
        chk(32'(drv_en), 32'h0c);
        wr(pin_port_pkg::LEVEL_IDX, 8'hf4);
        chk(32'(drv), 32'h04);
        settle();
        rd(pin_port_pkg::LEVEL_IDX, 32'h04);
        wr(pin_port_pkg::SET_IDX, 8'h08);
        wr(pin_port_pkg::SET_IDX, 8'h00);
        chk(32'(drv), 32'h0c);
        wr(pin_port_pkg::CLEAR_IDX, 8'h04);
        wr(pin_port_pkg::CLEAR_IDX, 8'h00);
        chk(32'(drv), 32'h08);
        rd(pin_port_pkg::SET_IDX, 32'h00);
        rd(pin_port_pkg::CLEAR_IDX, 32'h00);
        $display("output test done");
        wr(pin_port_pkg::DIR_IDX, 8'h04);
        ext_en <= 8'h08;
        settle();
        rd(pin_port_pkg::LEVEL_IDX, 32'h00);
        ext_val <= 8'h08;
        settle();
        rd(pin_port_pkg::LEVEL_IDX, 32'h08);
        wr(pin_port_pkg::CLEAR_IDX, 8'h08);
        wr(pin_port_pkg::DIR_IDX, 8'h0c);
        chk(32'(drv), 32'h08);
        $display("input test done");
        wr(pin_port_pkg::DIR_IDX, 8'h04);
        ext_en <= 8'h00;
        wr(pin_port_pkg::PULLUP_IDX, 8'hf7);
        chk(32'(pu), 32'h00);
        wr(pin_port_pkg::PULLUP_IDX, 8'hff);
        chk(32'(pu), 32'h08);
        rd(pin_port_pkg::PULLUP_IDX, 32'hff);
        rd(pin_port_pkg::DIR_IDX, 32'h04);
        $display("pull-up test done");
        summarize();
    end
endmodule
